// ---- hw/t2rc_pkg.sv ----
// Package for the reload/capture timer: mode codes, control bundle,
// reset values and prescaler constants.
// Assumes a single core clock; every user of these names writes t2rc_pkg::name.
package t2rc_pkg;

   // One-hot operating modes
   typedef enum logic [3:0] {
      MODE_RELOAD16 = 4'b0001,
      MODE_RELOAD8 = 4'b0010,
      MODE_CAPTURE16 = 4'b0100,
      MODE_CAPTURE8 = 4'b1000
   } t2rc_mode_t;

   // Control and clock-select bits, held by software outside this block
   typedef struct packed {
      logic splitModeSelect;
      logic captureEnableBit;
      logic captureSourceSelect;      // 0: USB start-of-frame, 1: slow oscillator fall
      logic runControlBit;
      logic lowByteIrqEnable;
      logic externalClockSelect;
      logic highByteSysclkSelect;
      logic lowByteSysclkSelect;
      logic irqEnable;
   } t2rc_ctrl_t;

   // Software write strobes with shared data
   typedef struct packed {
      logic countLowWe;
      logic countHighWe;
      logic reloadLowWe;
      logic reloadHighWe;
      logic flagWe;                   // Flags take wrData[1:0] = {high, low}
      logic [7:0] wrData;
   } t2rc_wr_t;

   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int DIV12_RATIO = 12;
   localparam logic [3:0] DIV12_LAST = 4'(DIV12_RATIO - 1);
   localparam logic [3:0] DIV12_RESET = 4'h0;
   localparam int FLAG_HIGH_POS = 1;
   localparam int FLAG_LOW_POS = 0;

endpackage

// ---- hw/t2rc_timer.sv ----
// Reload/capture timer: one 16-bit or two 8-bit auto-reload counters,
// with capture of the count into the reload bytes on a chosen event.
// Assumes control bits, write strobes and the USB frame pulse are synchronous
// to core_clk; the divided external clock and slow oscillator are treated as asynchronous.
`timescale 1ns/1ps
`default_nettype none

module t2rc_timer (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire t2rc_pkg::t2rc_ctrl_t ctrl,
   input wire t2rc_pkg::t2rc_wr_t wr,
   input wire logic extClkDiv8,
   input wire logic usbSofPulse,
   input wire logic lowFreqOscClk,
   output logic [7:0] countLowByte,
   output logic [7:0] countHighByte,
   output logic [7:0] reloadLowByte,
   output logic [7:0] reloadHighByte,
   output logic highOverflowFlag,
   output logic lowOverflowFlag,
   output logic irqReq
);

   function automatic t2rc_pkg::t2rc_mode_t decodeMode(input t2rc_pkg::t2rc_ctrl_t c);
      if (c.captureEnableBit && c.splitModeSelect) begin
         decodeMode = t2rc_pkg::MODE_CAPTURE8;
      end else if (c.captureEnableBit) begin
         decodeMode = t2rc_pkg::MODE_CAPTURE16;
      end else if (c.splitModeSelect) begin
         decodeMode = t2rc_pkg::MODE_RELOAD8;
      end else begin
         decodeMode = t2rc_pkg::MODE_RELOAD16;
      end
   endfunction

   function automatic logic pickTick(input logic sysSel, input logic extSel,
                                     input logic div12Tick, input logic extTick);
      if (sysSel) begin
         pickTick = 1'b1;
      end else if (extSel) begin
         pickTick = extTick;
      end else begin
         pickTick = div12Tick;
      end
   endfunction

   t2rc_pkg::t2rc_mode_t mode;
   logic [3:0] div12Cnt_r;
   logic div12Tick;
   logic extSync1_r;
   logic extSync2_r;
   logic extPrev_r;
   logic extTick;
   logic slowSync1_r;
   logic slowSync2_r;
   logic slowPrev_r;
   logic captureEvent;
   logic lowTick;
   logic highTick;
   logic split;
   logic capture;
   logic advLow;
   logic advHigh;
   logic lowWrap;
   logic highWrap;
   logic [7:0] countLow_nxt;
   logic [7:0] countHigh_nxt;

   assign mode = decodeMode(ctrl);
   assign split = (mode == t2rc_pkg::MODE_RELOAD8) || (mode == t2rc_pkg::MODE_CAPTURE8);
   assign capture = (mode == t2rc_pkg::MODE_CAPTURE16) || (mode == t2rc_pkg::MODE_CAPTURE8);

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         div12Cnt_r <= t2rc_pkg::DIV12_RESET;
      end else if (div12Cnt_r == t2rc_pkg::DIV12_LAST) begin
         div12Cnt_r <= t2rc_pkg::DIV12_RESET;
      end else begin
         div12Cnt_r <= div12Cnt_r + 4'h1;
      end
   end
   assign div12Tick = (div12Cnt_r == t2rc_pkg::DIV12_LAST);

   // two-stage synchroniser on the external clock, edge taken after stage two
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         extSync1_r <= 1'b0;
         extSync2_r <= 1'b0;
         extPrev_r <= 1'b0;
      end else begin
         extSync1_r <= extClkDiv8;
         extSync2_r <= extSync1_r;
         extPrev_r <= extSync2_r;
      end
   end
   assign extTick = extSync2_r && !extPrev_r;

   // Slow oscillator is asynchronous too, so it gets the same treatment
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         slowSync1_r <= 1'b0;
         slowSync2_r <= 1'b0;
         slowPrev_r <= 1'b0;
      end else begin
         slowSync1_r <= lowFreqOscClk;
         slowSync2_r <= slowSync1_r;
         slowPrev_r <= slowSync2_r;
      end
   end

   assign captureEvent = capture &&
      (ctrl.captureSourceSelect ? (slowPrev_r && !slowSync2_r) : usbSofPulse);

   // byte ticks; whole-count mode uses the low-byte select
   assign lowTick = pickTick(ctrl.lowByteSysclkSelect, ctrl.externalClockSelect,
                             div12Tick, extTick);
   assign highTick = pickTick(ctrl.highByteSysclkSelect, ctrl.externalClockSelect,
                              div12Tick, extTick);

   // split gates only the high byte with run
   // whole-count modes stop when run is clear
   assign advLow = split ? lowTick : (ctrl.runControlBit && lowTick);
   assign advHigh = split ? (ctrl.runControlBit && highTick)
                          : (advLow && (countLowByte == t2rc_pkg::BYTE_ALL_ONES));
   assign lowWrap = advLow && (countLowByte == t2rc_pkg::BYTE_ALL_ONES);
   assign highWrap = advHigh && (countHighByte == t2rc_pkg::BYTE_ALL_ONES);

   // Next count values
   always_comb begin
      countLow_nxt = countLowByte;
      countHigh_nxt = countHighByte;
      if (split) begin
         // capture split bytes wrap to zero
         if (advLow) begin
            countLow_nxt = lowWrap ? (capture ? t2rc_pkg::BYTE_ZERO : reloadLowByte)
                                   : countLowByte + 8'h01;
         end
         if (advHigh) begin
            countHigh_nxt = highWrap ? (capture ? t2rc_pkg::BYTE_ZERO : reloadHighByte)
                                     : countHighByte + 8'h01;
         end
      end else if (highWrap) begin
         countLow_nxt = capture ? t2rc_pkg::BYTE_ZERO : reloadLowByte;
         countHigh_nxt = capture ? t2rc_pkg::BYTE_ZERO : reloadHighByte;
      end else begin
         // carry from low byte into high byte
         if (advLow) begin
            countLow_nxt = countLowByte + 8'h01;
         end
         if (advHigh) begin
            countHigh_nxt = countHighByte + 8'h01;
         end
      end
   end

   // Count bytes; a software write beats counting in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         countLowByte <= t2rc_pkg::COUNT_RESET;
         countHighByte <= t2rc_pkg::COUNT_RESET;
      end else begin
         countLowByte <= wr.countLowWe ? wr.wrData : countLow_nxt;
         countHighByte <= wr.countHighWe ? wr.wrData : countHigh_nxt;
      end
   end

   // capture copies the count before this edge's update
   // both bytes copied in split capture
   // software may rewrite reload in any cycle without a capture event
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reloadLowByte <= t2rc_pkg::RELOAD_RESET;
         reloadHighByte <= t2rc_pkg::RELOAD_RESET;
      end else if (captureEvent) begin
         // Hardware capture wins so a timing sample is never lost
         reloadLowByte <= countLowByte;
         reloadHighByte <= countHighByte;
      end else begin
         if (wr.reloadLowWe) begin
            reloadLowByte <= wr.wrData;
         end
         if (wr.reloadHighWe) begin
            reloadHighByte <= wr.wrData;
         end
      end
   end

   // each byte wrap sets its flag
   // set wins over a software clear
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         highOverflowFlag <= 1'b0;
         lowOverflowFlag <= 1'b0;
      end else begin
         if (highWrap || captureEvent) begin
            highOverflowFlag <= 1'b1;
         end else if (wr.flagWe) begin
            highOverflowFlag <= wr.wrData[t2rc_pkg::FLAG_HIGH_POS];
         end
         if (lowWrap) begin
            lowOverflowFlag <= 1'b1;
         end else if (wr.flagWe) begin
            lowOverflowFlag <= wr.wrData[t2rc_pkg::FLAG_LOW_POS];
         end
      end
   end

   // low-byte source needs its own enable
   // split uses the same request rule
   // level holds until software clears the flags
   assign irqReq = ctrl.irqEnable &&
      (highOverflowFlag || (ctrl.lowByteIrqEnable && lowOverflowFlag));

endmodule

`default_nettype wire

// ---- bench/t2rc_timer_assertions.sv ----
// Port-level checks for the reload/capture timer.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module t2rc_timer_assertions (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire t2rc_pkg::t2rc_ctrl_t ctrl,
   input wire t2rc_pkg::t2rc_wr_t wr,
   input wire logic [7:0] countLowByte,
   input wire logic [7:0] countHighByte,
   input wire logic [7:0] reloadLowByte,
   input wire logic [7:0] reloadHighByte,
   input wire logic highOverflowFlag,
   input wire logic lowOverflowFlag,
   input wire logic irqReq,
   input wire logic usbSofPulse
);
   // All checks on the core clock, masked in reset
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire logic noCntWr = !wr.countLowWe && !wr.countHighWe;

   a_irq_level: assert property (irqReq == (ctrl.irqEnable && (highOverflowFlag ||
      ctrl.lowByteIrqEnable && lowOverflowFlag))) else $error("irq level wrong");
   // A reset also drops the flags, so the edge after it is excused
   a_high_sticky: assert property ($fell(highOverflowFlag) |-> $past(wr.flagWe) ||
      !$past(rst_b)) else $error("high flag dropped alone");
   a_low_sticky: assert property ($fell(lowOverflowFlag) |-> $past(wr.flagWe) ||
      !$past(rst_b)) else $error("low flag dropped alone");
   a_run_hold: assert property (!ctrl.splitModeSelect && !ctrl.runControlBit && noCntWr
      |=> $stable({countHighByte, countLowByte})) else $error("count moved while stopped");
   a_wrap_reload: assert property (!ctrl.splitModeSelect && !ctrl.captureEnableBit &&
      ctrl.runControlBit && ctrl.lowByteSysclkSelect && noCntWr &&
      {countHighByte, countLowByte} == 16'hFFFF |=> highOverflowFlag &&
      {countHighByte, countLowByte} == $past({reloadHighByte, reloadLowByte}))
      else $error("16-bit wrap missed reload");
   a_split_low_runs: assert property (ctrl.splitModeSelect && !ctrl.runControlBit &&
      ctrl.lowByteSysclkSelect && !wr.countLowWe && countLowByte != 8'hFF
      |=> countLowByte == $past(countLowByte) + 8'h01) else $error("low byte stalled");
   a_split_high_hold: assert property (ctrl.splitModeSelect && !ctrl.runControlBit &&
      !wr.countHighWe |=> $stable(countHighByte)) else $error("high byte ran while stopped");
   a_split_wrap: assert property (ctrl.splitModeSelect && !ctrl.captureEnableBit &&
      ctrl.lowByteSysclkSelect && !wr.countLowWe && countLowByte == 8'hFF
      |=> lowOverflowFlag && countLowByte == $past(reloadLowByte))
      else $error("low wrap missed reload");
   a_cap8_wrap: assert property (ctrl.splitModeSelect && ctrl.captureEnableBit &&
      ctrl.lowByteSysclkSelect && !wr.countLowWe && countLowByte == 8'hFF
      |=> lowOverflowFlag && countLowByte == 8'h00) else $error("capture low wrap not zero");
   a_sof_capture: assert property (ctrl.captureEnableBit && !ctrl.captureSourceSelect &&
      usbSofPulse |=> highOverflowFlag && reloadLowByte == $past(countLowByte) &&
      reloadHighByte == $past(countHighByte)) else $error("capture missed");
endmodule

bind t2rc_timer t2rc_timer_assertions chk_u (.core_clk, .rst_b, .ctrl, .wr, .countLowByte,
   .countHighByte, .reloadLowByte, .reloadHighByte, .highOverflowFlag, .lowOverflowFlag,
   .irqReq, .usbSofPulse);
`default_nettype wire

// ---- bench/t2rc_timer_test.sv ----
// Self-checking bench for the reload/capture timer.
// Assumes design and checker compiled first; inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module t2rc_timer_test;
   logic core_clk = 1'h0;
   logic rst_b = 1'h0;
   t2rc_pkg::t2rc_ctrl_t ctrl = '0;
   t2rc_pkg::t2rc_wr_t wr = '0;
   logic extClkDiv8 = 1'h0;
   logic usbSofPulse = 1'h0;
   logic lowFreqOscClk = 1'h0;
   logic [7:0] cLow, cHigh, rLow, rHigh;
   logic fHigh, fLow, irq;
   int numErrors = 0;
   int comparisons = 0;
   wire logic [15:0] cnt = {cHigh, cLow};
   wire logic [15:0] rel = {rHigh, rLow};
   wire logic [15:0] fl = {13'h0, fHigh, fLow, irq};

   // 100 MHz core clock
   always #5 core_clk = ~core_clk;

   t2rc_timer dut_u (.core_clk, .rst_b, .ctrl, .wr, .extClkDiv8, .usbSofPulse, .lowFreqOscClk,
      .countLowByte(cLow), .countHighByte(cHigh), .reloadLowByte(rLow), .reloadHighByte(rHigh),
      .highOverflowFlag(fHigh), .lowOverflowFlag(fLow), .irqReq(irq));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         numErrors++;
         $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobe bits: count low, count high, reload low, reload high, flags
   task automatic put(input logic [4:0] we, input logic [7:0] d);
      @(negedge core_clk) wr = {we, d};
      @(negedge core_clk) wr = '0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Main sequence; run bit is dropped before count writes so no tick is lost
   initial begin
      cyc(16);
      rst_b = 1'h1;
      cyc(1);
      chk(cnt | rel | fl, 16'h0000);
      $display("reset done");
      put(5'h02, 8'h12);
      put(5'h04, 8'h34);
      put(5'h08, 8'hFF);
      put(5'h10, 8'hFF);
      ctrl.lowByteSysclkSelect = 1'h1;
      ctrl.irqEnable = 1'h1;
      ctrl.runControlBit = 1'h1;
      cyc(1);
      ctrl.runControlBit = 1'h0;
      chk(cnt, 16'h1234);
      chk(fl, 16'h0007);
      put(5'h01, 8'h01);
      chk(fl, 16'h0002);
      ctrl.lowByteIrqEnable = 1'h1;
      cyc(5);
      chk(fl, 16'h0003);
      chk(cnt, 16'h1234);
      put(5'h01, 8'h00);
      ctrl.lowByteSysclkSelect = 1'h0;
      ctrl.runControlBit = 1'h1;
      cyc(24);
      ctrl.runControlBit = 1'h0;
      chk(cnt, 16'h1236);
      ctrl.externalClockSelect = 1'h1;
      ctrl.runControlBit = 1'h1;
      repeat (3) begin
         extClkDiv8 = 1'h1;
         cyc(2);
         extClkDiv8 = 1'h0;
         cyc(2);
      end
      cyc(4);
      ctrl.runControlBit = 1'h0;
      chk(cnt, 16'h1239);
      $display("reload16 done");
      put(5'h04, 8'hF0);
      put(5'h10, 8'hFE);
      ctrl.splitModeSelect = 1'h1;
      ctrl.lowByteSysclkSelect = 1'h1;
      cyc(2);
      chk(cnt, 16'h12F0);
      chk(fl, 16'h0003);
      ctrl.lowByteSysclkSelect = 1'h0;
      ctrl.externalClockSelect = 1'h0;
      put(5'h01, 8'h00);
      put(5'h08, 8'hFF);
      ctrl.highByteSysclkSelect = 1'h1;
      ctrl.runControlBit = 1'h1;
      cyc(1);
      ctrl.runControlBit = 1'h0;
      chk({8'h00, cHigh}, 16'h0012);
      chk(fl, 16'h0005);
      $display("split done");
      ctrl.splitModeSelect = 1'h0;
      ctrl.captureEnableBit = 1'h1;
      put(5'h01, 8'h00);
      put(5'h10, 8'hAB);
      put(5'h08, 8'hCD);
      usbSofPulse = 1'h1;
      cyc(1);
      usbSofPulse = 1'h0;
      chk(rel, 16'hCDAB);
      chk(fl, 16'h0005);
      ctrl.captureSourceSelect = 1'h1;
      put(5'h10, 8'h66);
      put(5'h08, 8'h55);
      lowFreqOscClk = 1'h1;
      cyc(4);
      lowFreqOscClk = 1'h0;
      cyc(5);
      chk(rel, 16'h5566);
      // Split capture: low byte wraps to zero, then a frame start copies both bytes
      put(5'h10, 8'hFE);
      ctrl.splitModeSelect = 1'h1;
      ctrl.lowByteSysclkSelect = 1'h1;
      ctrl.captureSourceSelect = 1'h0;
      cyc(2);
      chk(cnt, 16'h5500);
      usbSofPulse = 1'h1;
      cyc(1);
      usbSofPulse = 1'h0;
      chk(rel, 16'h5500);
      chk(fl, 16'h0007);
      $display("capture done");
      stop_test();
   end

   // Sequence needs about 110 cycles; a hang is cut at 2000
   initial begin
      cyc(2000);
      numErrors++;
      stop_test();
   end
endmodule
`default_nettype wire
